// ==== shared/lvdsrx_pkg.sv ====
// Constants and types shared by the LVDS receive deserializer files.
`default_nettype none
package lvdsrx_pkg;
  // System clock period and the static delay step, each in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned DELAY_STEP_PS = 25;
  // Word geometry: deserialization widths and the bypass width.
  localparam int unsigned MAX_WIDTH = 8;
  localparam logic [3:0] WIDTH_MIN = 4'h2;
  localparam logic [3:0] WIDTH_MAX = 4'h8;
  localparam logic [3:0] WIDTH_BYPASS = 4'h1;
  // Depth of the whole-cycle delay line behind the sampled serial bit.
  localparam int unsigned DLY_DEPTH = 4;
  // APB register byte offsets.
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_WORD = 12'h008;
  // Configuration register fields.
  localparam int unsigned CFG_DESER_BIT = 0;
  localparam int unsigned CFG_WIDTH_LSB = 4;
  localparam int unsigned CFG_CONN_BIT = 8;
  localparam int unsigned CFG_DELAY_LSB = 16;
  // Status register fields.
  localparam int unsigned STS_EN_BIT = 0;
  localparam int unsigned STS_BITCLK_BIT = 1;
  localparam int unsigned STS_WORDCLK_BIT = 2;
  localparam int unsigned STS_MODE_LSB = 4;
  localparam int unsigned STS_COUNT_LSB = 16;
  // Configuration reset values.
  localparam logic RST_DESER = 1'b1;
  localparam logic [3:0] RST_WIDTH = 4'h8;
  localparam logic RST_CONN = 1'b0;
  localparam logic [5:0] RST_DELAY = 6'h00;
  // Positions of the pin inputs inside the synchroniser bank.
  localparam int unsigned SYNC_BITCLK = 0;
  localparam int unsigned SYNC_WORDCLK = 1;
  localparam int unsigned SYNC_POS = 2;
  localparam int unsigned SYNC_NEG = 3;
  localparam int unsigned SYNC_W = 4;
  // Lane operating mode decoded from the configuration.
  typedef enum logic [1:0] {
    MODE_DESER,
    MODE_BYPASS,
    MODE_ALT
  } lvdsrx_mode_t;
endpackage
`default_nettype wire

// ==== logic/lvdsrx_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module lvdsrx_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] agreed;
  } lvdsrx_sync_state_t;

  lvdsrx_sync_state_t s;
  lvdsrx_sync_state_t next_s;

  // Stage one feeds only stage two; the filter looks at two and three alone.
  always_comb begin
    next_s = s;
    next_s.ff1 = async_in;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    // A bit moves only when both late stages hold the same new level.
    next_s.agreed = (s.ff2 & s.ff3) | (s.agreed & (s.ff2 | s.ff3));
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.agreed;
endmodule
`default_nettype wire

// ==== logic/lvdsrx_core.sv ====
// LVDS receive lane: pad sampling, static delay, deserializer, APB registers.
//
// Behaviour
// - The word output is as wide as the set width, one bit per serial bit.
// - With width one the deserializer is skipped and the bit goes straight out.
// - The alternate output runs only in bypass (width one or deserialization off) with alternate type.
// - Serial bits from the pads shift in on rising edges of the serial bit clock.
// - Each word is presented aligned, updated on the word clock rising edge.
// - Any width from two through eight may be selected.
// - With deserialization off and regular connection type the lane acts as a plain input buffer.
// - The core enable input turns the receive buffer on and off.
// - In bypass the connection type picks regular receive or the alternate clock route.
// - A static delay of zero to sixty-three steps of 25 ps is stored, but stays under one cycle and adds none.
`timescale 1ns/1ps
`default_nettype none
module lvdsrx_core (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [lvdsrx_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SERIAL_BIT_CLOCK,
  input wire logic PARALLEL_WORD_CLOCK,
  input wire logic DIFF_POSITIVE_PAD,
  input wire logic DIFF_NEGATIVE_PAD,
  input wire logic RX_ENABLE,
  output logic [lvdsrx_pkg::MAX_WIDTH-1:0] RX_DATA,
  output logic ALTERNATE_CLOCK_INPUT
);
  import lvdsrx_pkg::*;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic deser_en;
    logic [3:0] width;
    logic conn_alt;
    logic [5:0] delay;
    logic [DLY_DEPTH-2:0] dly_line;
    logic bit_hold;
    logic bit_clk_q;
    logic word_clk_q;
    logic [MAX_WIDTH-1:0] shreg;
    logic [MAX_WIDTH-1:0] rx_data;
    logic alt_out;
    logic [15:0] word_count;
  } lvdsrx_state_t;

  localparam lvdsrx_state_t RST_STATE = '{
    deser_en: RST_DESER,
    width: RST_WIDTH,
    conn_alt: RST_CONN,
    delay: RST_DELAY,
    default: '0
  };

  // Clamp the programmed width: below two is bypass, above eight is eight.
  function automatic logic [3:0] eff_width(input logic [3:0] w);
    if (w < WIDTH_MIN) begin
      return WIDTH_BYPASS;
    end else if (w > WIDTH_MAX) begin
      return WIDTH_MAX;
    end
    return w;
  endfunction

  // Mask of the low w bits of a word.
  function automatic logic [MAX_WIDTH-1:0] width_mask(input logic [3:0] w);
    logic [MAX_WIDTH-1:0] m;
    m = '0;
    for (int i = 0; i < MAX_WIDTH; i++) begin
      m[i] = (i < w);
    end
    return m;
  endfunction

  // Whole system cycles of delay for a setting, rounded down.
  function automatic logic [1:0] delay_taps(input logic [5:0] d);
    logic [15:0] ps;
    logic [15:0] cyc;
    ps = 16'(d) * 16'(DELAY_STEP_PS);
    cyc = ps / 16'(CLK_PERIOD_PS);
    if (cyc > 16'(DLY_DEPTH - 1)) begin
      return 2'(DLY_DEPTH - 1);
    end
    return 2'(cyc);
  endfunction

  lvdsrx_state_t s;
  lvdsrx_state_t next_s;
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_q;
  lvdsrx_mode_t mode;
  logic [3:0] w_eff;
  logic [MAX_WIDTH-1:0] mask;
  logic bit_raw;
  logic [DLY_DEPTH-1:0] dl_vec;
  logic [1:0] tap;
  logic bit_dly;
  logic bit_rise;
  logic word_rise;
  logic [MAX_WIDTH-1:0] next_shreg;
  logic apb_access;
  logic apb_done;
  logic [31:0] rd;
  logic rd_ok;

  // All pad and clock pins arrive from outside and are filtered together,
  // so data and clock keep their relative timing through the same latency.
  assign pin_raw[SYNC_BITCLK] = SERIAL_BIT_CLOCK;
  assign pin_raw[SYNC_WORDCLK] = PARALLEL_WORD_CLOCK;
  assign pin_raw[SYNC_POS] = DIFF_POSITIVE_PAD;
  assign pin_raw[SYNC_NEG] = DIFF_NEGATIVE_PAD;

  lvdsrx_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(CLK),
    .reset(RESET),
    .async_in(pin_raw),
    .sync_out(pin_q)
  );

  // Mode decode: bypass covers width one and deserialization switched off.
  always_comb begin
    w_eff = eff_width(s.width);
    mask = width_mask(w_eff);
    if (!s.deser_en || w_eff == WIDTH_BYPASS) begin
      mode = s.conn_alt ? MODE_ALT : MODE_BYPASS;
    end else begin
      mode = MODE_DESER;
    end
  end

  // Differential decode: equal pads carry no bit, so the last bit is held.
  // A disabled buffer reads as zero, but word clock edges still capture and count words.
  always_comb begin
    if (!RX_ENABLE) begin
      bit_raw = 1'b0;
    end else if (pin_q[SYNC_POS] != pin_q[SYNC_NEG]) begin
      bit_raw = pin_q[SYNC_POS];
    end else begin
      bit_raw = s.bit_hold;
    end
    // The 25 ps steps are far below one system cycle, so only whole
    // cycles of the total delay take effect; even the 1575 ps maximum adds none.
    dl_vec = {s.dly_line, bit_raw};
    tap = delay_taps(s.delay);
    bit_dly = dl_vec[tap];
    bit_rise = pin_q[SYNC_BITCLK] & ~s.bit_clk_q;
    word_rise = pin_q[SYNC_WORDCLK] & ~s.word_clk_q;
  end

  // New bits enter at bit zero, so after w bit edges the earliest bit of
  // the word sits at bit w-1 in every word period.
  always_comb begin
    next_shreg = s.shreg;
    if (bit_rise && RX_ENABLE && mode == MODE_DESER) begin
      next_shreg = {s.shreg[MAX_WIDTH-2:0], bit_dly};
    end
  end

  // APB decode: reads are answered in the first access cycle's next edge.
  always_comb begin
    apb_access = PSEL & PENABLE & ~s.pready;
    apb_done = PSEL & PENABLE & s.pready;
    rd = '0;
    rd_ok = 1'b1;
    if (PADDR == OFF_CONFIG) begin
      rd[CFG_DESER_BIT] = s.deser_en;
      rd[CFG_WIDTH_LSB +: 4] = s.width;
      rd[CFG_CONN_BIT] = s.conn_alt;
      rd[CFG_DELAY_LSB +: 6] = s.delay;
    end else if (PADDR == OFF_STATUS) begin
      rd[STS_EN_BIT] = RX_ENABLE;
      rd[STS_BITCLK_BIT] = pin_q[SYNC_BITCLK];
      rd[STS_WORDCLK_BIT] = pin_q[SYNC_WORDCLK];
      rd[STS_MODE_LSB +: 2] = mode;
      rd[STS_COUNT_LSB +: 16] = s.word_count;
    end else if (PADDR == OFF_WORD) begin
      rd = 32'(s.rx_data);
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Next-state logic for the bus slave, configuration and data path.
  always_comb begin
    next_s = s;
    next_s.pready = apb_access;
    next_s.pslverr = 1'b0;
    if (apb_access) begin
      next_s.prdata = PWRITE ? 32'h0000_0000 : rd;
      next_s.pslverr = ~rd_ok;
    end
    // Writes land only at the completing edge; status and word are read-only.
    if (apb_done && PWRITE && PADDR == OFF_CONFIG) begin
      next_s.deser_en = PWDATA[CFG_DESER_BIT];
      next_s.width = PWDATA[CFG_WIDTH_LSB +: 4];
      next_s.conn_alt = PWDATA[CFG_CONN_BIT];
      next_s.delay = PWDATA[CFG_DELAY_LSB +: 6];
    end
    next_s.dly_line = dl_vec[DLY_DEPTH-2:0];
    next_s.bit_hold = bit_raw;
    next_s.bit_clk_q = pin_q[SYNC_BITCLK];
    next_s.word_clk_q = pin_q[SYNC_WORDCLK];
    next_s.shreg = next_shreg;
    next_s.alt_out = 1'b0;
    case (mode)
      MODE_DESER: begin
        if (word_rise) begin
          next_s.rx_data = next_shreg & mask;
          next_s.word_count = s.word_count + 16'h0001;
        end else begin
          next_s.rx_data = s.rx_data & mask;
        end
      end
      MODE_BYPASS: begin
        next_s.rx_data = MAX_WIDTH'(bit_dly);
      end
      default: begin
        // The lane is lent to the PLL input; the word output stays quiet.
        next_s.rx_data = '0;
        next_s.alt_out = bit_dly;
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  // Every output comes straight from the state register.
  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign RX_DATA = s.rx_data;
  assign ALTERNATE_CLOCK_INPUT = s.alt_out;

  // Bits above the width stay zero once mode and width have settled.
  a_upper_bits_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    (mode == MODE_DESER && $past(mode) == MODE_DESER && $stable(s.width))
      |-> ((RX_DATA & ~mask) == '0))
    else $error("Word bits above the width are not zero.");

  // In bypass the output bit follows the delayed sample one cycle later.
  a_bypass_direct: assert property (
    @(posedge CLK) disable iff (RESET)
    (mode == MODE_BYPASS && w_eff == WIDTH_BYPASS)
      |=> (RX_DATA == MAX_WIDTH'($past(bit_dly))))
    else $error("Bypass bit did not reach the word output.");

  // The alternate output is high only after a cycle in alternate mode.
  a_alt_only_mode: assert property (
    @(posedge CLK) disable iff (RESET)
    ALTERNATE_CLOCK_INPUT |-> ($past(mode) == MODE_ALT && $past(RX_ENABLE)))
    else $error("Alternate output active outside alternate mode.");

  // A bit clock edge in deserializer mode shifts the delayed bit in.
  a_shift_on_edge: assert property (
    @(posedge CLK) disable iff (RESET)
    (bit_rise && RX_ENABLE && mode == MODE_DESER)
      |=> (s.shreg == {$past(s.shreg[MAX_WIDTH-2:0]), $past(bit_dly)}))
    else $error("Serial bit was not shifted on the bit clock edge.");

  // In steady deserializer mode the word changes only after a word edge.
  a_word_on_edge: assert property (
    @(posedge CLK) disable iff (RESET)
    ($changed(RX_DATA) && $past(mode) == MODE_DESER
      && $past(mode, 2) == MODE_DESER
      && $past(s.width) == $past(s.width, 2))
      |-> $past(word_rise))
    else $error("Word output changed without a word clock edge.");

  // A word edge captures the masked shift register for any legal width.
  a_word_capture: assert property (
    @(posedge CLK) disable iff (RESET)
    (word_rise && mode == MODE_DESER)
      |=> (RX_DATA == ($past(next_shreg) & $past(mask))
           && s.word_count == $past(s.word_count) + 16'h0001))
    else $error("Word capture did not match the shifted bits.");

  // With deserialization off and regular connection type the lane passes the bit like a plain buffer.
  a_plain_buffer: assert property (
    @(posedge CLK) disable iff (RESET)
    (!s.deser_en && !s.conn_alt) |=> (RX_DATA[0] == $past(bit_dly)))
    else $error("Plain input buffer did not pass the bit.");

  // A disabled buffer freezes the shift register and holds the alternate output low.
  a_enable_off: assert property (
    @(posedge CLK) disable iff (RESET)
    !RX_ENABLE |=> ($stable(s.shreg) && !ALTERNATE_CLOCK_INPUT))
    else $error("Receive path moved while the buffer was disabled.");

  // Alternate connection in bypass keeps the word output at zero.
  a_alt_word_quiet: assert property (
    @(posedge CLK) disable iff (RESET)
    (mode == MODE_ALT) |=> (RX_DATA == '0))
    else $error("Word output active while routed to the PLL input.");

  // The line keeps the previous decoded bit; tap zero takes it undelayed.
  a_delay_tap: assert property (
    @(posedge CLK) disable iff (RESET)
    (tap == 2'h0)
      |-> (bit_dly == bit_raw && s.dly_line[0] == $past(bit_raw)))
    else $error("Static delay tap selected the wrong sample.");

  // A bypass word carries the bit in position zero and nothing above it.
  a_bypass_upper_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    (mode == MODE_BYPASS)
      |=> (RX_DATA[MAX_WIDTH-1:1] == '0))
    else $error("Bypass word has bits set above bit zero.");

  // Outside the alternate route the alternate output stays low.
  a_alt_off_normal: assert property (
    @(posedge CLK) disable iff (RESET)
    (mode != MODE_ALT)
      |=> !ALTERNATE_CLOCK_INPUT)
    else $error("Alternate output high on the normal route.");

  // A disabled buffer with no whole-cycle delay reads as zero in bypass.
  a_enable_reads_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    (!RX_ENABLE && tap == 2'h0 && mode == MODE_BYPASS)
      |=> (RX_DATA == '0))
    else $error("Disabled buffer passed a bit to the word output.");

  // The word count moves only on a word clock edge in deserializer mode.
  a_count_on_edge: assert property (
    @(posedge CLK) disable iff (RESET)
    !(word_rise && mode == MODE_DESER)
      |=> $stable(s.word_count))
    else $error("Word count moved without a word clock edge.");
endmodule
`default_nettype wire

// ==== verif/lvdsrx_tx_model.sv ====
// Behavioural model of the external LVDS serial transmitter.
`timescale 1ns/1ps
`default_nettype none
module lvdsrx_tx_model (
  input wire logic clk,
  output logic bit_clk,
  output logic word_clk,
  output logic pad_p,
  output logic pad_n
);
  // Clocks stand still and the pull-ups hold both pads high when idle.
  initial begin
    bit_clk = 1'b0;
    word_clk = 1'b0;
    pad_p = 1'b1;
    pad_n = 1'b1;
  end
  // Drive one level on the pads with no clock, for the bypass paths.
  task automatic level(input logic b);
    @(posedge clk);
    pad_p <= b;
    pad_n <= ~b;
  endtask
  // Send w bits earliest first; the word clock rises with the last bit
  // clock rise, so it runs at the bit rate divided by the width.
  task automatic send(input int w, input logic [7:0] d);
    for (int i = w - 1; i >= 0; i--) begin
      @(posedge clk);
      pad_p <= d[i];
      pad_n <= ~d[i];
      if (i == w - 1) word_clk <= 1'b0;
      repeat (2) @(posedge clk);
      bit_clk <= 1'b1;
      if (i == 0) word_clk <= 1'b1;
      repeat (4) @(posedge clk);
      bit_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    // The driver lets go after the hold time; equal pads leave the receiver holding the last bit.
    pad_p <= 1'b1;
    pad_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== verif/lvdsrx_core_tb.sv ====
// Self-checking bench for the LVDS receive lane and its APB registers.
`timescale 1ns/1ps
`default_nettype none
module lvdsrx_core_tb;
  import lvdsrx_pkg::*;
  logic clk, reset, psel, penable, pwrite, rx_enable, pready, pslverr;
  logic bclk, wclk, pp, pn, alternate_clock_input, err, v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, c;
  logic [7:0] rx_data, d;
  logic [5:0] dly;
  logic q[$];
  int miscompares = 0;
  int tests_run = 0;
  int sent = 0;
  lvdsrx_core DUT (.CLK(clk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SERIAL_BIT_CLOCK(bclk), .PARALLEL_WORD_CLOCK(wclk),
    .DIFF_POSITIVE_PAD(pp), .DIFF_NEGATIVE_PAD(pn), .RX_ENABLE(rx_enable),
    .RX_DATA(rx_data), .ALTERNATE_CLOCK_INPUT(alternate_clock_input));
  lvdsrx_tx_model tx (.clk(clk), .bit_clk(bclk), .word_clk(wclk),
    .pad_p(pp), .pad_n(pn));
  // Free-running 100 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; the answer is taken at the edge that sees pready.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      close_out();
    end
  endtask
  // Configuration word built from its fields.
  function automatic logic [31:0] cfg(logic de, logic [3:0] w, logic cn,
                                      logic [5:0] dl);
    return (32'(dl) << CFG_DELAY_LSB) | (32'(cn) << CFG_CONN_BIT) |
           (32'(w) << CFG_WIDTH_LSB) | 32'(de);
  endfunction
  // Reference word: the last w bits seen, the earliest at the top.
  function automatic logic [31:0] model_word(int w);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < w; i++) r[i] = q[q.size() - 1 - i];
    return r;
  endfunction
  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    close_out();
  end
  // Main sequence: reset, register map, every width, bypass paths.
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rx_enable = 1'b1;
    void'($urandom(32'hAE2FBFC8));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    chk("rx_data reset", 32'(rx_data), 32'h0);
    apb(1'b0, OFF_CONFIG, 32'h0);
    c = cfg(RST_DESER, RST_WIDTH, RST_CONN, RST_DELAY);
    chk("config reset", rd, c);
    apb(1'b1, 12'hFF0, 32'hFFFF_FFFF);
    chk("unmapped error", 32'(err), 32'h1);
    apb(1'b0, OFF_CONFIG, 32'h0);
    chk("config kept", rd, c);
    $display("Test reset and register map done");
    for (int w = 2; w <= 8; w++) begin
      dly = 6'($urandom_range(63));
      // Width eight is written as fifteen, so the clamp to eight is used.
      c = cfg(1'b1, w == 8 ? 4'hF : 4'(w), 1'(w), dly);
      apb(1'b1, OFF_CONFIG, c);
      apb(1'b0, OFF_CONFIG, 32'h0);
      chk("config", rd, c);
      for (int k = 0; k < 2; k++) begin
        d = 8'($urandom);
        for (int i = w - 1; i >= 0; i--) q.push_back(d[i]);
        tx.send(w, d);
        sent++;
        repeat (10) @(posedge clk);
        chk("rx_data", 32'(rx_data), model_word(w));
        chk("alt deser", 32'(alternate_clock_input), 32'h0);
      end
      apb(1'b0, OFF_WORD, 32'h0);
      chk("word reg", rd, model_word(w));
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("mode", (rd >> STS_MODE_LSB) & 32'h3, 32'(MODE_DESER));
      chk("count", rd >> STS_COUNT_LSB, 32'(sent));
      chk("clock levels", (rd >> STS_BITCLK_BIT) & 32'h3,
          32'h2);
      $display("Test width %0d done", w);
    end
    // Mode 0 is width one, 1 is deserializer off, 2 the alternate route.
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, OFF_CONFIG, m == 1 ? cfg(1'b0, 4'h8, 1'b0, 6'h3F) :
          cfg(1'b1, WIDTH_BYPASS, m == 2, 6'h3F));
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("mode", (rd >> STS_MODE_LSB) & 32'h3,
          m == 2 ? 32'(MODE_ALT) : 32'(MODE_BYPASS));
      for (int b = 0; b < 4; b++) begin
        v = (b != 1);
        tx.level(v);
        if (b == 3) rx_enable <= 1'b0;
        repeat (10) @(posedge clk);
        if (b == 3) v = 1'b0;
        chk("bypass bit", 32'(rx_data), m == 2 ? 32'h0 : 32'(v));
        chk("alt", 32'(alternate_clock_input), m == 2 ? 32'(v) : 32'h0);
      end
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("enable status", rd & 32'h1, 32'h0);
      rx_enable <= 1'b1;
      $display("Test bypass mode %0d done", m);
    end
    close_out();
  end
endmodule
`default_nettype wire
